// ---- hdl/dplc_loop.sv ----
// digital pwm loop: filter, clamps, current share and monitor
`timescale 1ns/1ps
`include "dplc_regs.svh"

module dplc_loop #(
  parameter int MON_INTERVAL = `DPLC_MON_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  input  wire dplc_pkg::dplc_fsw_t       fsw_sel_i,
  input  wire dplc_pkg::dplc_duty_limit_t duty_limit_register_i,
  input  wire dplc_pkg::dplc_coef_t      coef_i,
  input  wire logic [7:0]                window_i,
  input  wire logic signed [7:0]         err_i,
  input  wire logic                      share_i,
  input  wire logic                      adc_done_i,
  input  wire logic [7:0]                adc_data_i,
  output logic                           pwm_o,
  output logic                           share_o,
  output logic                           share_oe_o,
  output logic                           adc_start_o,
  output logic [1:0]                     adc_sel_o,
  output logic [7:0]                     vout_monitor_value_o,
  output logic [7:0]                     iout_monitor_value_o,
  output logic [7:0]                     temperature_monitor_value_o,
  output logic [6:0]                     duty_o
);
  import dplc_pkg::*;

  localparam logic [1:0] CH_VOUT = 2'h0;
  localparam logic [1:0] CH_IOUT = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;

  // the reload counter is only 12 bits wide
  if (MON_INTERVAL < 1 || MON_INTERVAL > 4095) begin : g_bad_interval
    $error("MON_INTERVAL must lie in 1..4095");
  end

  // full-width signed product so no filter term wraps before the sum
  function automatic logic signed [33:0] smul(input logic signed [33:0] a,
                                              input logic signed [33:0] b);
    return a * b;
  endfunction

  // saturate a filter sum to the 24-bit state width
  function automatic logic signed [23:0] sat24(input logic signed [33:0] v);
    if (v > 34'sh00007FFFFF) begin
      return 24'sh7FFFFF;
    end else if (v < -34'sh0000800000) begin
      return -24'sh800000;
    end
    return v[23:0];
  endfunction

  // clamp a signed duty request into 0..limit
  function automatic logic [6:0] clamp_duty(input logic signed [23:0] v,
                                            input logic [6:0] lim);
    if (v <= 24'sh0) begin
      return 7'h0;
    end else if (v >= $signed({17'h0, lim})) begin
      return lim;
    end
    return v[6:0];
  endfunction

  // inductor resistance rises with heat, so scale the reading back down
  function automatic logic [7:0] temp_corr(input logic [7:0] raw,
                                           input logic [7:0] tmp);
    logic signed [8:0]  dt;
    logic signed [17:0] adj;
    logic signed [17:0] res;
    dt  = $signed({1'b0, tmp}) - $signed({1'b0, `DPLC_TEMP_REF});
    adj = ($signed({1'b0, raw}) * dt) >>> 8;
    res = $signed({10'h0, raw}) - adj;
    if (res < 18'sh0) begin
      return 8'h0;
    end else if (res > 18'sh000FF) begin
      return 8'hFF;
    end
    return res[7:0];
  endfunction

  dplc_state_t s_q;
  dplc_state_t s_d;
  logic [6:0]  period;
  logic        tick;
  logic [7:0]  iout_corr;

  // switching period from the frequency select
  always_comb begin
    case (fsw_sel_i)
      DPLC_FSW_750K: period = 7'(`DPLC_PER_750K);
      DPLC_FSW_1M:   period = 7'(`DPLC_PER_1M);
      default:       period = 7'(`DPLC_PER_500K);
    endcase
  end

  assign tick      = (s_q.sw_cnt >= period - 7'h1);
  assign iout_corr = temp_corr(adc_data_i, s_q.temp);

  // whole next-state computation of the block
  always_comb begin
    logic signed [8:0]  e;
    logic signed [33:0] num;
    logic signed [33:0] fb;
    logic signed [23:0] y;
    logic [6:0]         nd;
    logic [13:0]        dc;
    e   = -$signed({err_i[7], err_i});
    num = smul(34'($signed({coef_i.numerator_coef_zero_high,
                            coef_i.numerator_coef_zero_low})), 34'(e))
        + smul(34'($signed({coef_i.numerator_coef_one_high,
                            coef_i.numerator_coef_one_low})), 34'(s_q.x1))
        + smul(34'($signed({coef_i.numerator_coef_two_high,
                            coef_i.numerator_coef_two_low})), 34'(s_q.x2))
        + smul(34'($signed({coef_i.numerator_coef_three_high,
                            coef_i.numerator_coef_three_low})), 34'(s_q.x3));
    fb  = (smul(34'($signed(coef_i.denominator_coef_one)), 34'(s_q.y1))
         + smul(34'($signed(coef_i.denominator_coef_two)), 34'(s_q.y2))
         + smul(34'($signed(coef_i.denominator_coef_three)), 34'(s_q.y3)))
         >>> `DPLC_DEN_SHIFT;
    y   = sat24(num - fb);
    nd  = s_q.duty;
    dc  = 14'h0;
    s_d = s_q;
    s_d.adc_start = 1'b0;

    // switching counter, share pulse and share line measurement
    s_d.sw_cnt   = tick ? 7'h0 : s_q.sw_cnt + 7'h1;
    s_d.share_oe = (s_d.sw_cnt < s_q.iout[7:1]);
    s_d.share_low = tick ? 7'h0
                  : s_q.share_low + {6'h0, ~share_i};

    if (tick) begin
      // history keeps running during saturation so release is bumpless
      s_d.x1 = e;
      s_d.x2 = s_q.x1;
      s_d.x3 = s_q.x2;
      s_d.y1 = y;
      s_d.y2 = s_q.y1;
      s_d.y3 = s_q.y2;
      // the weaker module raises its trim until its pulse matches the line
      // one bit wider so a full-scale reading cannot wrap to zero
      if ({1'b0, s_q.iout[7:1]} + 8'h1 < {1'b0, s_q.share_low}) begin
        if (s_q.trim < `DPLC_TRIM_MAX) begin
          s_d.trim = s_q.trim + 5'h1;
        end
      end else if (s_q.trim != 5'h0) begin
        s_d.trim = s_q.trim - 5'h1;
      end
      if (duty_limit_register_i.sat_en &&
          err_i > $signed({1'b0, window_i[6:0]})) begin
        nd = 7'h0;
      end else if (duty_limit_register_i.sat_en &&
                   err_i < -$signed({1'b0, window_i[6:0]})) begin
        nd = duty_limit_register_i.limit;
      end else begin
        nd = clamp_duty((y >>> `DPLC_OUT_SHIFT) + $signed({19'h0, s_q.trim}),
                        duty_limit_register_i.limit);
      end
      s_d.duty = nd;
      dc = {7'h0, nd} * {7'h0, period};
      s_d.duty_cyc = dc[13:7];
    end
    s_d.pwm = (s_d.sw_cnt < s_d.duty_cyc);

    // monitor sequencer: one converter shared by three channels
    case (s_q.ms)
      DPLC_MS_IDLE: begin
        if (s_q.mon_cnt == 12'h0) begin
          s_d.adc_start = 1'b1;
          s_d.ms = DPLC_MS_CONV;
        end else begin
          s_d.mon_cnt = s_q.mon_cnt - 12'h1;
        end
      end
      DPLC_MS_CONV: begin
        if (adc_done_i) begin
          case (s_q.ch)
            CH_VOUT: s_d.vout = adc_data_i;
            CH_IOUT: s_d.iout = iout_corr;
            default: s_d.temp = adc_data_i;
          endcase
          s_d.ch = (s_q.ch == CH_TEMP) ? CH_VOUT : s_q.ch + 2'h1;
          s_d.mon_cnt = 12'(MON_INTERVAL - 1);
          s_d.ms = DPLC_MS_IDLE;
        end
      end
      default: s_d.ms = DPLC_MS_IDLE;
    endcase
  end

  // one register stage for all state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.ms <= DPLC_MS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pwm_o                       = s_q.pwm;
  assign share_o                     = 1'b0;
  assign share_oe_o                  = s_q.share_oe;
  assign adc_start_o                 = s_q.adc_start;
  assign adc_sel_o                   = s_q.ch;
  assign vout_monitor_value_o        = s_q.vout;
  assign iout_monitor_value_o        = s_q.iout;
  assign temperature_monitor_value_o = s_q.temp;
  assign duty_o                      = s_q.duty;

  // idle cycles since the last conversion request
  logic [12:0] gap_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_q <= 13'h0;
    end else if (s_q.adc_start) begin
      gap_q <= 13'h0;
    end else if (s_q.ms == DPLC_MS_IDLE) begin
      gap_q <= gap_q + 13'h1;
    end
  end

  duty_le_limit_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tick |=> duty_o <= $past(duty_limit_register_i.limit))
    else $error("duty above limit");
  sat_to_zero_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tick && duty_limit_register_i.sat_en
      && err_i > $signed({1'b0, window_i[6:0]}) |=> duty_o == 7'h0)
    else $error("positive excursion did not force zero");
  sat_to_limit_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tick && duty_limit_register_i.sat_en
      && err_i < -$signed({1'b0, window_i[6:0]})
      |=> duty_o == $past(duty_limit_register_i.limit))
    else $error("negative excursion did not force limit");
  duty_per_cycle_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !tick |=> $stable(duty_o))
    else $error("duty changed between switching cycles");
  pwm_zero_off_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tick && duty_limit_register_i.limit == 7'h0 |=> !pwm_o [*2])
    else $error("pwm high with zero limit");
  mon_rate_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    gap_q <= 13'(MON_INTERVAL + 1))
    else $error("conversion request late");
  vout_update_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    s_q.ms == DPLC_MS_CONV && adc_done_i && adc_sel_o == CH_VOUT
      |=> vout_monitor_value_o == $past(adc_data_i))
    else $error("voltage monitor not refreshed");
  iout_corr_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    s_q.ms == DPLC_MS_CONV && adc_done_i && adc_sel_o == CH_IOUT
      && temperature_monitor_value_o == `DPLC_TEMP_REF
      |=> iout_monitor_value_o == $past(adc_data_i))
    else $error("current reading altered at reference temperature");
  trim_up_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tick && {1'b0, s_q.iout[7:1]} + 8'h1 < {1'b0, s_q.share_low}
      && s_q.trim < `DPLC_TRIM_MAX |=> s_q.trim == $past(s_q.trim) + 5'h1)
    else $error("share trim did not rise");
endmodule

// ---- hdl/dplc_regs.svh ----
// constants of the digital pwm loop control block
`ifndef DPLC_REGS_SVH
`define DPLC_REGS_SVH
`define DPLC_CLK_HZ        40000000
`define DPLC_FSW_500K_HZ   500000
`define DPLC_FSW_750K_HZ   750000
`define DPLC_FSW_1M_HZ     1000000
// switching periods in clock cycles, rounded down
`define DPLC_PER_500K      (`DPLC_CLK_HZ / `DPLC_FSW_500K_HZ)
`define DPLC_PER_750K      (`DPLC_CLK_HZ / `DPLC_FSW_750K_HZ)
`define DPLC_PER_1M        (`DPLC_CLK_HZ / `DPLC_FSW_1M_HZ)
// monitor: one conversion slot every 100 us, so each quantity every 300 us
`define DPLC_MON_SLOT_NS   100000
`define DPLC_MON_CYC       (`DPLC_MON_SLOT_NS / 25)
// filter scaling
`define DPLC_DEN_SHIFT     6
`define DPLC_OUT_SHIFT     12
// current sense temperature reference code
`define DPLC_TEMP_REF      8'h19
`define DPLC_TRIM_MAX      5'h0F
`endif

// ---- hdl/dplc_pkg.sv ----
// types of the digital pwm loop control block
package dplc_pkg;
  typedef struct packed {
    logic       sat_en;
    logic [6:0] limit;
  } dplc_duty_limit_t;

  typedef struct packed {
    logic [7:0] numerator_coef_zero_high;
    logic [7:0] numerator_coef_zero_low;
    logic [7:0] numerator_coef_one_high;
    logic [7:0] numerator_coef_one_low;
    logic [7:0] numerator_coef_two_high;
    logic [7:0] numerator_coef_two_low;
    logic [7:0] numerator_coef_three_high;
    logic [7:0] numerator_coef_three_low;
    logic [7:0] denominator_coef_one;
    logic [7:0] denominator_coef_two;
    logic [7:0] denominator_coef_three;
  } dplc_coef_t;

  typedef enum logic [1:0] {
    DPLC_FSW_500K = 2'h0,
    DPLC_FSW_750K = 2'h1,
    DPLC_FSW_1M   = 2'h2
  } dplc_fsw_t;

  typedef enum logic [1:0] {
    DPLC_MS_IDLE = 2'b01,
    DPLC_MS_CONV = 2'b10
  } dplc_mon_state_t;

  typedef struct packed {
    logic [6:0]         sw_cnt;
    logic [6:0]         duty;
    logic [6:0]         duty_cyc;
    logic               pwm;
    logic               share_oe;
    logic [6:0]         share_low;
    logic [4:0]         trim;
    logic signed [8:0]  x1;
    logic signed [8:0]  x2;
    logic signed [8:0]  x3;
    logic signed [23:0] y1;
    logic signed [23:0] y2;
    logic signed [23:0] y3;
    dplc_mon_state_t    ms;
    logic [1:0]         ch;
    logic [11:0]        mon_cnt;
    logic               adc_start;
    logic [7:0]         vout;
    logic [7:0]         iout;
    logic [7:0]         temp;
  } dplc_state_t;
endpackage

// ---- test/dplc_adc_model.sv ----
// partner model: the 8-bit converter that serves the loop block's monitor
`timescale 1ns/1ps
module dplc_adc_model (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       adc_start_i,
  input  wire logic [1:0] adc_sel_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] vout_val_i,
  input  wire logic [7:0] iout_val_i,
  input  wire logic [7:0] temp_val_i,
  output logic            adc_done_o,
  output logic [7:0]      adc_data_o
);
  logic [3:0] wait_q;
  logic [1:0] sel_q;

  // one conversion at a time; slow mode stretches the answer to 12 cycles
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q     <= 4'h0;
      sel_q      <= 2'h0;
      adc_done_o <= 1'b0;
      adc_data_o <= 8'hFF;
    end else begin
      adc_done_o <= 1'b0;
      // data toggles between results so stale values never look valid
      adc_data_o <= ~adc_data_o;
      if (adc_start_i) begin
        wait_q <= slow_i ? 4'hC : 4'h1;
        sel_q  <= adc_sel_i;
      end else if (wait_q == 4'h1) begin
        wait_q     <= 4'h0;
        adc_done_o <= 1'b1;
        adc_data_o <= (sel_q == 2'h0) ? vout_val_i :
                      (sel_q == 2'h1) ? iout_val_i : temp_val_i;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule

// ---- test/testbench.sv ----
// self-checking bench of the digital pwm loop block
`timescale 1ns/1ps
`include "dplc_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module testbench;
  import dplc_pkg::*;
  typedef struct packed {
    logic             sat;
    logic [6:0]       lim;
    logic [7:0]       win;
    logic signed [7:0] err;
    logic [6:0]       duty;
  } dplc_tb_row_t;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  dplc_fsw_t fsw = DPLC_FSW_1M;
  dplc_duty_limit_t lim = '0;
  dplc_coef_t coef = '0;
  logic [7:0] win = 8'h00;
  logic signed [7:0] err = 8'sh00;
  logic ext_pull = 1'b0;
  logic slow = 1'b0;
  logic [7:0] tval = 8'h19;
  logic pwm_o, share_o, share_oe_o, adc_start_o, adc_done, share_i;
  logic [1:0] adc_sel_o;
  logic [7:0] adc_data, vmon, imon, tmon;
  logic [6:0] duty_o;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int cp, cs, per, k;
  dplc_tb_row_t rows[9] = '{
    '{1'b1, 7'd100, 8'd10, -8'sd5, 7'd5}, '{1'b1, 7'd100, 8'd10, 8'sd5, 7'd0},
    '{1'b1, 7'd100, 8'd10, 8'sd11, 7'd0}, '{1'b1, 7'd100, 8'd10, -8'sd11, 7'd100},
    '{1'b1, 7'd100, 8'd10, -8'sd10, 7'd10}, '{1'b0, 7'd100, 8'd10, -8'sd30, 7'd30},
    '{1'b0, 7'd50, 8'd10, -8'sd100, 7'd50}, '{1'b1, 7'd127, 8'd0, -8'sd1, 7'd127},
    '{1'b1, 7'd0, 8'd10, -8'sd5, 7'd0}};

  // open-drain share line: low while this block or another module pulls
  assign share_i = ~(share_oe_o | ext_pull);

  dplc_loop #(.MON_INTERVAL(20)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .fsw_sel_i(fsw),
    .duty_limit_register_i(lim), .coef_i(coef), .window_i(win),
    .err_i(err), .share_i(share_i), .adc_done_i(adc_done),
    .adc_data_i(adc_data), .pwm_o(pwm_o), .share_o(share_o),
    .share_oe_o(share_oe_o), .adc_start_o(adc_start_o),
    .adc_sel_o(adc_sel_o), .vout_monitor_value_o(vmon),
    .iout_monitor_value_o(imon), .temperature_monitor_value_o(tmon),
    .duty_o(duty_o));

  dplc_adc_model u_adc (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .adc_start_i(adc_start_o),
    .adc_sel_i(adc_sel_o), .slow_i(slow), .vout_val_i(8'hA5),
    .iout_val_i(8'h40), .temp_val_i(tval), .adc_done_o(adc_done),
    .adc_data_o(adc_data));

  always #12.5 clk_i = ~clk_i;

  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ceiling well above the roughly 6000 cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // high cycles of pwm and share pull over p clocks
  task automatic count_hi(input int p, output int c_pwm, output int c_sh);
    c_pwm = 0;
    c_sh = 0;
    repeat (p) begin
      @(posedge clk_i);
      c_pwm += int'(pwm_o === 1'b1);
      c_sh += int'(share_oe_o === 1'b1);
    end
  endtask

  // clocks from one pwm rise to the next, bounded
  task automatic meas_per(output int p);
    int j;
    p = 0;
    for (j = 0; j < 200 && pwm_o !== 1'b0; j++) @(posedge clk_i);
    for (j = 0; j < 200 && pwm_o !== 1'b1; j++) @(posedge clk_i);
    for (j = 0; j < 200 && pwm_o !== 1'b0; j++) begin @(posedge clk_i); p++; end
    for (j = 0; j < 200 && pwm_o !== 1'b1; j++) begin @(posedge clk_i); p++; end
  endtask

  initial begin
    // unit gain on the current sample only: filter output equals -err
    coef.numerator_coef_zero_high = 8'h10;
    wait_cyc(20);
    reset_n_i <= 1'b1;
    for (k = 0; k < 9; k++) begin
      @(posedge clk_i);
      lim <= '{rows[k].sat, rows[k].lim};
      win <= rows[k].win;
      err <= rows[k].err;
      wait_cyc(160);
      `CHK("duty", rows[k].duty, duty_o)
    end
    // switching rate per selection, duty 30 with window saturation off
    for (k = 0; k < 4; k++) begin
      @(posedge clk_i);
      lim <= '{1'b0, 7'd100};
      err <= -8'sd30;
      fsw <= dplc_fsw_t'(k);
      wait_cyc(240);
      cp = (k == 1) ? 53 : (k == 2) ? 40 : 80;
      meas_per(per);
      `CHK("period", cp, per)
      count_hi(cp, cs, per);
      `CHK("pwm_on", (30 * cp) >> 7, cs)
    end
    fsw <= DPLC_FSW_1M;
    `CHK("vout_mon", 8'hA5, vmon)
    `CHK("iout_mon", 8'h40, imon)
    `CHK("temp_mon", 8'h19, tmon)
    // hotter reading trims current: 64 - 64*32/256, slow converter
    slow <= 1'b1;
    tval <= 8'h39;
    wait_cyc(400);
    `CHK("temp_mon", 8'h39, tmon)
    `CHK("iout_mon", 8'h38, imon)
    // another module pulls the share line: trim climbs to its ceiling
    lim <= '{1'b1, 7'd100};
    err <= 8'sd0;
    ext_pull <= 1'b1;
    wait_cyc(1000);
    `CHK("share_trim", {2'b00, `DPLC_TRIM_MAX}, duty_o)
    count_hi(40, cp, cs);
    `CHK("share_pull", 28, cs)
    `CHK("share_o", 1'b0, share_o)
    ext_pull <= 1'b0;
    wait_cyc(800);
    `CHK("share_idle", 7'd0, duty_o)
    // integrator pole, gain in the low byte: duty climbs one step per tick
    lim <= '{1'b0, 7'd100};
    err <= -8'sd32;
    coef.numerator_coef_zero_high <= 8'h00;
    coef.numerator_coef_zero_low <= 8'h80;
    coef.denominator_coef_one <= 8'hC0;
    wait_cyc(80);
    cp = duty_o;
    wait_cyc(400);
    `CHK("integrator", 7'(cp + 10), duty_o)
    coef.numerator_coef_zero_high <= 8'h10;
    coef.numerator_coef_zero_low <= 8'h00;
    coef.denominator_coef_one <= 8'h00;
    lim <= '{1'b1, 7'd100};
    // large dip: duty must reach the limit within one switching cycle
    err <= -8'sd40;
    for (k = 0; k < 100 && duty_o !== 7'd100; k++) @(posedge clk_i);
    `CHK("sat_time", 1'b1, k <= 42)
    // reset in mid-run clears every output
    reset_n_i <= 1'b0;
    wait_cyc(3);
    `CHK("rst_duty", 7'd0, duty_o)
    `CHK("rst_mon", 24'h0, {vmon, imon, tmon})
    `CHK("rst_pwm", 1'b0, pwm_o)
    reset_n_i <= 1'b1;
    for (k = 0; k < 4 && adc_start_o !== 1'b1; k++) @(posedge clk_i);
    `CHK("mon_restart", 1'b1, adc_start_o)
    end_sim();
  end
endmodule
